// ---- bench/iomb_exec_test.sv ----
// Self-checking testbench for the instruction execution block
`timescale 1ns/10ps
module iomb_exec_test;
  import iomb_pkg::*;

  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  logic        clk_sys_i;      // System clock
  logic        rst_i;          // Synchronous reset
  logic [13:0] instr_i;        // Instruction word
  logic        instr_valid_i;  // Slot issued
  logic [7:0]  addr_i;         // Register address
  logic [7:0]  wdata_i;        // Register write data
  logic        wr_i;           // Write strobe
  logic        rd_i;           // Read strobe
  logic [7:0]  rdata_o;        // Read data
  logic [12:0] pc_o;           // Program counter
  logic        pc_load_o;      // Branch pulse
  logic        nop_slot_o;     // Swallowed slot pulse
  logic [7:0]  w_o;            // Working register
  logic        zero_o;         // Zero flag
  int          n_mismatch;     // Mismatches seen
  int          checks_done;    // Comparisons made
  logic [12:0] exp_pc;         // Expected program counter
  logic [7:0]  exp_w;          // Expected working register

  iomb_exec dut_u (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .instr_i       (instr_i),
    .instr_valid_i (instr_valid_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .rdata_o       (rdata_o),
    .pc_o          (pc_o),
    .pc_load_o     (pc_load_o),
    .nop_slot_o    (nop_slot_o),
    .w_o           (w_o),
    .zero_o        (zero_o)
  );

  // Free running clock, 4 ns period
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  // Prints the counts and the verdict, then stops
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Compares a multi-bit value
  task automatic chk_data(input string what, input logic [12:0] exp, input logic [12:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Compares a single flag
  task automatic chk_flag(input string what, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask

  // ****************************************************************
  // Encoders and access tasks
  // ****************************************************************
  // File-register instruction word
  function automatic logic [13:0] f_op(input logic [5:0] opc, input logic d,
                                       input logic [6:0] f);
    return {opc, d, f};
  endfunction

  // Register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // Register read, data checked in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1;
    chk_data("read data", {5'h00, exp}, {5'h00, rdata_o});
  endtask

  // Issues one slot and leaves valid high for a following slot
  task automatic issue(input logic [13:0] ins);
    @(posedge clk_sys_i);
    instr_i       <= ins;
    instr_valid_i <= 1'b1;
    exp_pc = exp_pc + 13'h0001;
  endtask

  // Ends a run of slots and lets the results settle
  task automatic idle();
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  // One slot, then the working register, zero flag, counter and no-op pulse
  task automatic do_op(input logic [13:0] ins, input logic [7:0] ew, input logic ez,
                       input logic en);
    issue(ins);
    idle();
    exp_w = ew;
    chk_data("working register", {5'h00, ew}, {5'h00, w_o});
    chk_flag("zero flag", ez, zero_o);
    chk_data("program counter", exp_pc, pc_o);
    chk_flag("no-op pulse", en, nop_slot_o);
  endtask

  // Jump followed at once by a slot that must be swallowed
  task automatic jump_chk(input logic [7:0] latch, input logic [10:0] k, input logic z,
                          input logic [13:0] nx);
    logic [12:0] t;
    t = {latch[4:3], k};
    wr_reg(IOMB_ADDR_PCHL, latch);
    wr_reg(IOMB_ADDR_STATUS, {5'h00, z, 2'b00});
    issue({IOMB_OPC_JUMP, k});
    issue(nx);
    #1;
    chk_data("jump target", t, pc_o);
    chk_flag("jump load pulse", 1'b1, pc_load_o);
    chk_flag("zero after jump", z, zero_o);
    idle();
    exp_pc = t + 13'h0001;
    chk_data("pc after no-op", exp_pc, pc_o);
    chk_flag("no-op pulse", 1'b1, nop_slot_o);
    chk_flag("load pulse ended", 1'b0, pc_load_o);
    chk_data("w after no-op", {5'h00, exp_w}, {5'h00, w_o});
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    $display("unexpected run length: expected end seen hang");
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_i = 1'b1;
    instr_i = 14'h0000;
    instr_valid_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    exp_pc = IOMB_RST_PC;
    exp_w = IOMB_RST_W;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk_data("reset pc", 13'h0000, pc_o);
    chk_data("reset w", 13'h0000, {5'h00, w_o});
    chk_flag("reset zero", 1'b0, zero_o);
    rd_chk(8'h05, IOMB_RST_FILE);
    // Increment with destination select and wrap
    wr_reg(8'h05, 8'hff);
    do_op(f_op(IOMB_OPC_INC, 1'b0, 7'h05), 8'h00, 1'b1, 1'b0);
    rd_chk(8'h05, 8'hff);
    do_op(f_op(IOMB_OPC_INC, 1'b1, 7'h05), 8'h00, 1'b1, 1'b0);
    rd_chk(8'h05, 8'h00);
    wr_reg(8'h06, 8'h7e);
    do_op(f_op(IOMB_OPC_INC, 1'b0, 7'h06), 8'h7f, 1'b0, 1'b0);
    // Increment-skip, nonzero then zero result
    wr_reg(IOMB_ADDR_STATUS, 8'h04);
    do_op(f_op(IOMB_OPC_INC_SKIP, 1'b1, 7'h06), 8'h7f, 1'b1, 1'b0);
    rd_chk(8'h06, 8'h7f);
    do_op({IOMB_OPC_OR_LIT, 8'h80}, 8'hff, 1'b0, 1'b0);
    wr_reg(8'h07, 8'hff);
    wr_reg(IOMB_ADDR_STATUS, 8'h00);
    do_op(f_op(IOMB_OPC_INC_SKIP, 1'b0, 7'h07), 8'h00, 1'b0, 1'b0);
    rd_chk(IOMB_ADDR_STATUS, 8'h01);
    do_op({IOMB_OPC_OR_LIT, 8'h5a}, 8'h00, 1'b0, 1'b1);
    // OR literal at both ends of the range
    do_op({IOMB_OPC_OR_LIT, 8'h00}, 8'h00, 1'b1, 1'b0);
    do_op({IOMB_OPC_OR_LIT, 8'ha5}, 8'ha5, 1'b0, 1'b0);
    do_op({IOMB_OPC_OR_LIT, 8'hff}, 8'hff, 1'b0, 1'b0);
    // OR working register with file register
    wr_reg(IOMB_ADDR_W_REG, 8'h0f);
    wr_reg(8'h08, 8'hf0);
    do_op(f_op(IOMB_OPC_OR_FILE, 1'b1, 7'h08), 8'h0f, 1'b0, 1'b0);
    rd_chk(8'h08, 8'hff);
    wr_reg(IOMB_ADDR_W_REG, 8'h00);
    wr_reg(8'h09, 8'h00);
    do_op(f_op(IOMB_OPC_OR_FILE, 1'b0, 7'h09), 8'h00, 1'b1, 1'b0);
    // Move file register, zero flag follows even onto itself
    do_op(f_op(IOMB_OPC_MOVE, 1'b1, 7'h08), 8'h00, 1'b0, 1'b0);
    rd_chk(8'h08, 8'hff);
    do_op(f_op(IOMB_OPC_MOVE, 1'b1, 7'h09), 8'h00, 1'b1, 1'b0);
    do_op(f_op(IOMB_OPC_MOVE, 1'b0, 7'h08), 8'hff, 1'b0, 1'b0);
    // Jumps with each latch setting, one followed by another jump
    wr_reg(IOMB_ADDR_W_REG, 8'h00);
    exp_w = 8'h00;
    jump_chk(8'h18, 11'h7fe, 1'b1, {IOMB_OPC_OR_LIT, 8'h3c});
    jump_chk(8'h0f, 11'h000, 1'b0, {IOMB_OPC_JUMP, 11'h111});
    jump_chk(8'he7, 11'h2a5, 1'b1, {IOMB_OPC_OR_LIT, 8'h01});
    jump_chk(8'h10, 11'h400, 1'b0, {IOMB_OPC_OR_LIT, 8'h02});
    // Skip pending survives an idle gap
    wr_reg(IOMB_ADDR_STATUS, 8'h00);
    issue({IOMB_OPC_JUMP, 11'h055});
    idle();
    exp_pc = {2'b10, 11'h055};
    chk_data("pc after jump", exp_pc, pc_o);
    rd_chk(IOMB_ADDR_STATUS, 8'h01);
    do_op({IOMB_OPC_OR_LIT, 8'h01}, 8'h00, 1'b0, 1'b1);
    // Unknown code runs as a plain slot, then counter and latch reads
    do_op(14'h0000, 8'h00, 1'b0, 1'b0);
    rd_chk(IOMB_ADDR_PC_LO, 8'h57);
    rd_chk(IOMB_ADDR_PC_HI, 8'h10);
    rd_chk(IOMB_ADDR_PCHL, 8'h10);
    rd_chk(8'h90, 8'h00);
    finish_test();
  end

endmodule

// ---- design/iomb_alu.sv ----
// Result path: computes the value and where it goes for one instruction
`timescale 1ns/10ps
module iomb_alu
  import iomb_pkg::*;
(
  input  iomb_pkg::iomb_op_t op_i,     // Operation kind
  input  wire logic         dest_i,    // Destination select bit
  input  wire logic [7:0]   w_i,       // Working register
  input  wire logic [7:0]   fval_i,    // Addressed file register
  input  wire logic [7:0]   lit_i,     // Literal operand
  output logic [7:0]        res_o,     // Result value
  output logic              wr_w_o,    // Result goes to working register
  output logic              wr_f_o,    // Result goes to file register
  output logic              z_upd_o,   // Zero flag follows the result
  output logic              skip_o     // Next slot becomes a no-op
);

  // ****************************************************************
  // Result value
  // ****************************************************************
  // Increment wraps modulo 256 by truncation
  // increment wraps
  wire logic [7:0] inc_val = 8'(fval_i + 8'h01);
  wire logic       file_op = (op_i == IOMB_OP_INC_SKIP) || (op_i == IOMB_OP_INC) ||
                             (op_i == IOMB_OP_OR_FILE) || (op_i == IOMB_OP_MOVE);

  always_comb
  begin
    case (op_i)
      IOMB_OP_INC_SKIP: res_o = inc_val;
      IOMB_OP_INC:      res_o = inc_val;
      IOMB_OP_OR_LIT:   res_o = w_i | lit_i;
      IOMB_OP_OR_FILE:  res_o = w_i | fval_i;
      IOMB_OP_MOVE:     res_o = fval_i;
      default:          res_o = 8'h00;
    endcase
  end

  // ****************************************************************
  // Destination and flag effects
  // ****************************************************************
  assign wr_w_o  = (op_i == IOMB_OP_OR_LIT) || (file_op && !dest_i);
  assign wr_f_o  = file_op && dest_i;
  assign z_upd_o = (op_i == IOMB_OP_INC) || (op_i == IOMB_OP_OR_LIT) ||
                   (op_i == IOMB_OP_OR_FILE) || (op_i == IOMB_OP_MOVE);
  assign skip_o  = (op_i == IOMB_OP_INC_SKIP) && iomb_is_zero(inc_val);

endmodule

// ---- design/iomb_decode.sv ----
// Instruction decoder: splits the instruction word into kind and fields
`timescale 1ns/10ps
module iomb_decode
  import iomb_pkg::*;
(
  input  wire logic [13:0]  instr_i,   // Instruction word
  output iomb_pkg::iomb_op_t op_o,     // Operation kind
  output logic              dest_o,    // 1: file register, 0: working register
  output logic [6:0]        faddr_o,   // File register index
  output logic [7:0]        lit_o,     // Eight-bit literal
  output logic [10:0]       k11_o      // Branch immediate
);

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  assign dest_o  = instr_i[IOMB_DEST_BIT];
  assign faddr_o = instr_i[IOMB_FADDR_MSB:0];
  assign lit_o   = instr_i[IOMB_LIT_MSB:0];
  assign k11_o   = instr_i[IOMB_K11_MSB:0];

  // Opcode groups
  wire logic [5:0] opc6 = instr_i[13:8];
  wire logic [2:0] opc3 = instr_i[13:11];

  // Kind selection; unknown codes run as a no-op
  assign op_o = (opc3 == IOMB_OPC_JUMP)     ? IOMB_OP_JUMP     :
                (opc6 == IOMB_OPC_INC_SKIP) ? IOMB_OP_INC_SKIP :
                (opc6 == IOMB_OPC_INC)      ? IOMB_OP_INC      :
                (opc6 == IOMB_OPC_OR_LIT)   ? IOMB_OP_OR_LIT   :
                (opc6 == IOMB_OPC_OR_FILE)  ? IOMB_OP_OR_FILE  :
                (opc6 == IOMB_OPC_MOVE)     ? IOMB_OP_MOVE     :
                                              IOMB_OP_NOP;

endmodule

// ---- design/iomb_exec.sv ----
// Execution block top: state, register port and checks for six instructions
`timescale 1ns/10ps
module iomb_exec
  import iomb_pkg::*;
#(
  parameter int NUM_FILES = IOMB_FILES    // File registers held here
)
(
  input  wire logic        clk_sys_i,     // System clock, 250 MHz
  input  wire logic        rst_i,         // Synchronous reset, active high
  input  wire logic [13:0] instr_i,       // Instruction word
  input  wire logic        instr_valid_i, // One instruction cycle is issued
  input  wire logic [7:0]  addr_i,        // Software address
  input  wire logic [7:0]  wdata_i,       // Software write data
  input  wire logic        wr_i,          // Software write strobe
  input  wire logic        rd_i,          // Software read strobe
  output logic [7:0]       rdata_o,       // Software read data, next cycle
  output logic [12:0]      pc_o,          // Program counter
  output logic             pc_load_o,     // Branch loaded the counter
  output logic             nop_slot_o,    // Last slot was swallowed by a skip or branch
  output logic [7:0]       w_o,           // Working register
  output logic             zero_o         // Zero flag
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]  file_q [NUM_FILES];  // File registers
  logic [7:0]  w_q;                 // Working register
  logic [7:0]  pchl_q;              // PC high latch
  logic [12:0] pc_q;                // Program counter
  logic        zero_q;              // Zero flag
  logic        flush_q;             // Next issued slot becomes a no-op
  logic        pc_load_q;           // Branch pulse
  logic        nop_slot_q;          // Replaced slot pulse
  logic [7:0]  rdata_q;             // Read data register

  iomb_op_t    op;                  // Decoded kind
  logic        dest;                // Destination select
  logic [6:0]  faddr;               // File index
  logic [7:0]  lit;                 // Literal
  logic [10:0] k11;                 // Branch immediate
  logic [7:0]  res;                 // Result value
  logic        wr_w;                // Result to working register
  logic        wr_f;                // Result to file register
  logic        z_upd;               // Zero flag follows result
  logic        skip;                // Skip request

  // ****************************************************************
  // Decode and result path
  // ****************************************************************
  iomb_decode u_decode (
    .instr_i (instr_i),
    .op_o    (op),
    .dest_o  (dest),
    .faddr_o (faddr),
    .lit_o   (lit),
    .k11_o   (k11)
  );

  // Operand from the addressed file register
  wire logic [7:0] fval = file_q[faddr];

  iomb_alu u_alu (
    .op_i    (op),
    .dest_i  (dest),
    .w_i     (w_q),
    .fval_i  (fval),
    .lit_i   (lit),
    .res_o   (res),
    .wr_w_o  (wr_w),
    .wr_f_o  (wr_f),
    .z_upd_o (z_upd),
    .skip_o  (skip)
  );

  // ****************************************************************
  // Execution qualifiers
  // ****************************************************************
  // A slot executes unless a skip or branch has claimed it
  wire logic exec     = instr_valid_i && !flush_q;
  // Slot swallowed as the second cycle of a two-cycle instruction
  wire logic nop_slot = instr_valid_i && flush_q;
  wire logic jump     = exec && (op == IOMB_OP_JUMP);
  wire logic exec_w   = exec && wr_w;
  wire logic exec_f   = exec && wr_f;
  wire logic exec_z   = exec && z_upd;

  // Software writes yield to an executing instruction
  wire logic sw_wr     = wr_i && !exec;
  wire logic sw_file   = sw_wr && !addr_i[7];
  wire logic sw_w      = sw_wr && (addr_i == IOMB_ADDR_W_REG);
  wire logic sw_pchl   = sw_wr && (addr_i == IOMB_ADDR_PCHL);
  wire logic sw_status = sw_wr && (addr_i == IOMB_ADDR_STATUS);

  // Branch target: latch bits on top, immediate below
  // latch top bits
  wire logic [12:0] jump_pc = {pchl_q[IOMB_PCHL_LSB+1:IOMB_PCHL_LSB], k11};

  // ****************************************************************
  // Next values
  // ****************************************************************
  // destination select
  wire logic [7:0] next_w = exec_w ? res : (sw_w ? wdata_i : w_q);
  wire logic next_zero = exec_z    ? iomb_is_zero(res) :
                         sw_status ? wdata_i[IOMB_STAT_Z_BIT] : zero_q;
  wire logic [12:0] next_pc = jump ? jump_pc :
                              instr_valid_i ? 13'(pc_q + 13'h0001) : pc_q;
  wire logic next_flush = exec ? (skip || (op == IOMB_OP_JUMP)) :
                          (nop_slot ? 1'b0 : flush_q);

  // Read multiplexer; unmapped addresses read zero
  wire logic [7:0] stat_val = {5'h00, zero_q, 1'b0, flush_q};
  wire logic [7:0] rd_val =
    !addr_i[7]                   ? file_q[addr_i[6:0]] :
    (addr_i == IOMB_ADDR_W_REG)  ? w_q                 :
    (addr_i == IOMB_ADDR_PCHL)   ? pchl_q              :
    (addr_i == IOMB_ADDR_STATUS) ? stat_val            :
    (addr_i == IOMB_ADDR_PC_LO)  ? pc_q[7:0]           :
    (addr_i == IOMB_ADDR_PC_HI)  ? {3'h0, pc_q[12:8]}  : 8'h00;

  // ****************************************************************
  // Core state
  // ****************************************************************
  // Working register, flag, counter and skip state
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      w_q        <= IOMB_RST_W;
      pchl_q     <= IOMB_RST_PCHL;
      pc_q       <= IOMB_RST_PC;
      zero_q     <= 1'b0;
      flush_q    <= 1'b0;
      pc_load_q  <= 1'b0;
      nop_slot_q <= 1'b0;
    end
    else
    begin
      w_q        <= next_w;
      pchl_q     <= sw_pchl ? wdata_i : pchl_q;
      pc_q       <= next_pc;
      zero_q     <= next_zero;
      flush_q    <= next_flush;
      pc_load_q  <= jump;
      nop_slot_q <= nop_slot;
    end
  end

  // File registers: instruction result first, then software
  always_ff @(posedge clk_sys_i)
  begin
    for (int i = 0; i < NUM_FILES; i++)
    begin
      if (rst_i)
        file_q[i] <= IOMB_RST_FILE;
      else if (exec_f && (faddr == 7'(i)))
        file_q[i] <= res;
      else if (sw_file && (addr_i[6:0] == 7'(i)))
        file_q[i] <= wdata_i;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_i ? rd_val : 8'h00;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o    = rdata_q;
  assign pc_o       = pc_q;
  assign pc_load_o  = pc_load_q;
  assign nop_slot_o = nop_slot_q;
  assign w_o        = w_q;
  assign zero_o     = zero_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Executing increment-skip that lands on zero
  sequence s_skip_arm;
    exec && (op == IOMB_OP_INC_SKIP) && skip;
  endsequence

  // Claimed slot followed by a quiet cycle
  sequence s_slot_swallowed;
    nop_slot_o && !flush_q && !pc_load_o;
  endsequence

  property p_dest_w;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && wr_w && (op != IOMB_OP_OR_LIT) |-> !dest ##1 w_q == $past(res);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("result missed W");

  property p_dest_f;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec_f |=> file_q[$past(faddr)] == $past(res) && $stable(w_q);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("result missed file");

  property p_skip;
    @(posedge clk_sys_i) disable iff (rst_i)
    s_skip_arm |=> flush_q && $stable(zero_o);
  endproperty
  a_skip: assert property (p_skip) else $error("skip not armed");

  property p_slot;
    @(posedge clk_sys_i) disable iff (rst_i)
    flush_q && instr_valid_i |=> s_slot_swallowed ##0 ($stable(w_q) || $past(sw_w));
  endproperty
  a_slot: assert property (p_slot) else $error("claimed slot executed");

  property p_jump_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    jump |=> pc_o[10:0] == $past(instr_i[10:0]) && pc_load_o;
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("bad jump low");

  property p_jump_high;
    @(posedge clk_sys_i) disable iff (rst_i)
    jump |=> pc_o[12:11] == $past(pchl_q[4:3]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("bad jump high");

  property p_jump_two;
    @(posedge clk_sys_i) disable iff (rst_i)
    jump |=> flush_q && $stable(zero_o) && $stable(w_o);
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not 2 cycles");

  property p_or_lit;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_OR_LIT) |=> w_o == ($past(w_q) | $past(instr_i[7:0]));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("bad OR literal");

  property p_inc;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_INC) |-> 8'(res - fval) == 8'h01 && z_upd;
  endproperty
  a_inc: assert property (p_inc) else $error("bad increment");

  property p_or_file;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_OR_FILE) |-> res == (w_q | fval) && z_upd;
  endproperty
  a_or_file: assert property (p_or_file) else $error("bad OR file");

  property p_move_test;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_MOVE) && dest |=> zero_o == ($past(fval) == 8'h00);
  endproperty
  a_move_test: assert property (p_move_test) else $error("move skipped Z");

  property p_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec_z |=> zero_o == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_wrap;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_INC_SKIP) && (fval == 8'hff) |-> res == 8'h00 ##1 flush_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment no wrap");

  // Plain increment sets zero only when the operand wraps
  property p_inc_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_INC) |=> zero_o == ($past(fval) == 8'hff);
  endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("increment zero wrong");

  // Nonzero increment-skip lets the next slot run
  property p_skip_pass;
    @(posedge clk_sys_i) disable iff (rst_i)
    exec && (op == IOMB_OP_INC_SKIP) && (fval != 8'hff) |=> !flush_q;
  endproperty
  a_skip_pass: assert property (p_skip_pass) else $error("skip on nonzero");

  // Any executed jump word loads the counter and claims a slot
  property p_jump_always;
    @(posedge clk_sys_i) disable iff (rst_i)
    instr_valid_i && !flush_q && (instr_i[13:11] == IOMB_OPC_JUMP) |=> pc_load_o && flush_q;
  endproperty
  a_jump_always: assert property (p_jump_always) else $error("jump not taken");

endmodule

// ---- shared/iomb_pkg.sv ----
// Shared constants, types and helpers for the instruction execution block
package iomb_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int IOMB_DATA_W  = 8;        // Data path width
  localparam int IOMB_INSTR_W = 14;       // Instruction word width
  localparam int IOMB_PC_W    = 13;       // Program counter width
  localparam int IOMB_FILES   = 128;      // File registers, index 0 to 127
  localparam int IOMB_ADDR_W  = 8;        // Software address width

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  localparam int IOMB_DEST_BIT  = 7;      // Destination select bit
  localparam int IOMB_FADDR_MSB = 6;      // File address top bit
  localparam int IOMB_K11_MSB   = 10;     // Branch immediate top bit
  localparam int IOMB_LIT_MSB   = 7;      // Literal top bit
  localparam logic [5:0] IOMB_OPC_INC_SKIP = 6'h0f; // Bits 13:8
  localparam logic [5:0] IOMB_OPC_INC      = 6'h0a; // Bits 13:8
  localparam logic [5:0] IOMB_OPC_OR_FILE  = 6'h04; // Bits 13:8
  localparam logic [5:0] IOMB_OPC_MOVE     = 6'h08; // Bits 13:8
  localparam logic [5:0] IOMB_OPC_OR_LIT   = 6'h38; // Bits 13:8
  localparam logic [2:0] IOMB_OPC_JUMP     = 3'h5;  // Bits 13:11

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IOMB_ADDR_W_REG  = 8'h80; // Working register
  localparam logic [7:0] IOMB_ADDR_PCHL   = 8'h81; // PC high latch
  localparam logic [7:0] IOMB_ADDR_STATUS = 8'h82; // Zero flag, skip pending
  localparam logic [7:0] IOMB_ADDR_PC_LO  = 8'h83; // PC bits 7:0
  localparam logic [7:0] IOMB_ADDR_PC_HI  = 8'h84; // PC bits 12:8
  localparam int IOMB_STAT_Z_BIT    = 2;  // Zero flag position
  localparam int IOMB_STAT_SKIP_BIT = 0;  // Skip pending position
  localparam int IOMB_PCHL_LSB      = 3;  // Latch bits 4:3 feed PC 12:11

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  IOMB_RST_W    = 8'h00;
  localparam logic [7:0]  IOMB_RST_PCHL = 8'h00;
  localparam logic [7:0]  IOMB_RST_FILE = 8'h00;
  localparam logic [12:0] IOMB_RST_PC   = 13'h0000;

  // Operation kinds after decode
  typedef enum {
    IOMB_OP_NOP, IOMB_OP_INC_SKIP, IOMB_OP_INC, IOMB_OP_JUMP,
    IOMB_OP_OR_LIT, IOMB_OP_OR_FILE, IOMB_OP_MOVE
  } iomb_op_t;

  // True when an eight-bit value is zero
  function automatic logic iomb_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

endpackage
